// File: afds_pkg.sv
// What this block does
// RL1 - Line mode: <20 ohm short, >3k open
// RL2 - Ramp up 10 ms, +10 with supply
// RL3 - Ramp down 10 ms, +10 with supply
// RL4 - Short-check plateau fixed 80 ms
// RL5 - Multiplier 1,2,4,8 from three-bit field
// RL6 - Load plateau 86*X or (140-2Tru)*X
// RL7 - Short test current 200/40 mA
// RL8 - Open test current 40/2 mA
// RL9 - Permanent diagnostic when biased and enabled
// RL10 - Turn-on results kept until over-current
// RL11 - Permanent: only hard shorts and across
// RL12 - Restart cycle 2 ms with output check
// RL13 - Plateau cycle 80 ms, writes fault bytes
// RL14 - Enable clear: restart every 2 ms
// RL15 - Enable clear: fault bits cleared, unreported
// RL16 - Enable set: one restart, then resume
// RL17 - Overload persists: run plateau cycle
// RL18 - Then restart every 2 ms, keep results
// RL19 - Plateau sets flag bit 5
// RL20 - Host read in restart requests plateau
// RL21 - Reading fourth byte clears all four
// RL22 - Host picks mode per channel pair
// RL23 - Independent sequencer per channel
package afds_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MULT = 8'h04;
  localparam logic [7:0] OFS_RAMP = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_FAULT0 = 8'h10;
  localparam int POS_DIAG_EN = 0;
  localparam int POS_MODE_24 = 1;
  localparam int POS_MODE_13 = 2;
  localparam int POS_MULT = 5;
  localparam int POS_GND = 0;
  localparam int POS_VS = 1;
  localparam int POS_OPEN = 2;
  localparam int POS_ACROSS = 3;
  localparam int POS_PLAT_DONE = 5;
  localparam int POS_VALID = 6;
  localparam logic [7:0] RAMP_RST = 8'h08;
  localparam logic [9:0] RISE_MS = 10'h00A;
  localparam logic [9:0] SUPPLY_MS = 10'h00A;
  localparam logic [9:0] SHORT_PLAT_MS = 10'h050;
  localparam logic [9:0] LOAD_PLAT_MS = 10'h056;
  localparam logic [9:0] PULSE_SPAN_MS = 10'h08C;
  localparam logic [6:0] RESTART_MS = 7'h02;
  localparam logic [6:0] PLATEAU_MS = 7'h50;
  localparam logic [7:0] SHORT_SPK_MA = 8'hC8;
  localparam logic [7:0] SHORT_LINE_MA = 8'h28;
  localparam logic [7:0] OPEN_SPK_MA = 8'h28;
  localparam logic [7:0] OPEN_LINE_MA = 8'h02;
  localparam logic [11:0] LINE_SHORT_OHM = 12'h014;
  localparam logic [11:0] LINE_OPEN_OHM = 12'hBB8;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_SS_UP, SEQ_SS_PLAT, SEQ_SS_DN,
                            SEQ_LD_UP, SEQ_LD_PLAT, SEQ_LD_DN} afds_seq_e;
  typedef enum logic [1:0] {CH_PLAY, CH_RESTART, CH_PLATEAU} afds_ch_e;
endpackage : afds_pkg

// File: afds_top.sv
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module afds_top
  import afds_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Channel sense pins
  input wire logic [3:0] overCurrentPin,
  input wire logic [3:0] shortGndPin,
  input wire logic [3:0] shortVsPin,
  input wire logic [3:0] shortAcrossPin,
  input wire logic [3:0] reachShortCurPin,
  input wire logic [3:0] reachOpenCurPin,
  input wire logic ampBiasedPin,
  // Outputs to the power stage
  output logic [3:0] chanShutdown,
  output logic [3:0] chanPlateau,
  output logic [2:0] seqPhase,
  output logic analogSupplyEn,
  output logic [3:0] lineModeOut,
  output logic [31:0] shortTestCurrent,
  output logic [31:0] openTestCurrent
);

  localparam int SW = 25;

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [SW-1:0] flt;
    logic [2:0] ctrl;
    logic [2:0] multCode;
    logic [7:0] rampMs;
    logic [3:0][7:0] fault;
    logic [31:0] rdata;
    logic [31:0] msCnt;
    logic msTick;
    afds_seq_e seq;
    logic [9:0] seqCnt;
    logic diagPrev;
    logic anaEn;
    logic [3:0][7:0] seqRes;
    afds_ch_e [3:0] chSt;
    logic [3:0][6:0] chCnt;
    logic [3:0] first;
    logic [3:0] replot;
    logic [3:0][2:0] acc;
    logic [3:0] chOff;
    logic [3:0][7:0] shortThr;
    logic [3:0][7:0] openThr;
    logic [3:0] platOut;
  } afds_state_s;

  afds_state_s st_q;
  afds_state_s st_d;

  // Multiplier code 0..3 selects 1,2,4,8; higher codes saturate at 8.
  function automatic logic [3:0] multFactor(input logic [2:0] code);
    logic [3:0] f;
    f = 4'h8;
    case (code)
      3'h0: f = 4'h1;
      3'h1: f = 4'h2;
      3'h2: f = 4'h4;
      default: f = 4'h8;
    endcase
    return f;
  endfunction : multFactor

  // Bit 2 steers channels 1 and 3, bit 1 steers channels 2 and 4.
  function automatic logic lineModeOf(input logic [2:0] ctrl, input int ch);
    return (ch % 2 == 0) ? ctrl[POS_MODE_13] : ctrl[POS_MODE_24];
  endfunction : lineModeOf

  logic [SW-1:0] pinsIn;
  logic [3:0] oc;
  logic [3:0] sGnd;
  logic [3:0] sVs;
  logic [3:0] sAcross;
  logic [3:0] hiCur;
  logic [3:0] loCur;
  logic biased;
  logic diagEn;
  logic [9:0] span;
  logic [9:0] tpMs;
  logic [9:0] upMs;
  logic rdHit;
  logic [2:0] rdIdx;

  assign pinsIn = {ampBiasedPin, reachOpenCurPin, reachShortCurPin, shortAcrossPin,
                   shortVsPin, shortGndPin, overCurrentPin};
  assign oc = st_q.flt[3:0];
  assign sGnd = st_q.flt[7:4];
  assign sVs = st_q.flt[11:8];
  assign sAcross = st_q.flt[15:12];
  assign hiCur = st_q.flt[19:16];
  assign loCur = st_q.flt[23:20];
  assign biased = st_q.flt[24];
  assign diagEn = st_q.ctrl[POS_DIAG_EN];
  assign span = PULSE_SPAN_MS - {1'b0, st_q.rampMs, 1'b0};
  assign upMs = RISE_MS + SUPPLY_MS;
  assign rdHit = regRd && (regAddr[7:4] == OFS_FAULT0[7:4]) && (regAddr[1:0] == 2'h0);
  assign rdIdx = {1'b0, regAddr[3:2]};

  // ---------------------------------------------------------------------------
  // Load-check plateau length
  // ---------------------------------------------------------------------------
  always_comb
  begin
    if ({st_q.rampMs, 1'b0} < 9'(PULSE_SPAN_MS) && span > SHORT_PLAT_MS)
    begin
      tpMs = 10'(LOAD_PLAT_MS * multFactor(st_q.multCode)); // RL6 RL5
    end
    else if ({st_q.rampMs, 1'b0} < 9'(PULSE_SPAN_MS))
    begin
      tpMs = 10'(span * multFactor(st_q.multCode)); // RL6
    end
    else
    begin
      tpMs = 10'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    // Pin inputs: a change is taken once stages two and three agree.
    st_d.s1 = pinsIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int b = 0; b < SW; b++)
    begin
      if (st_q.s2[b] == st_q.s3[b])
      begin
        st_d.flt[b] = st_q.s3[b];
      end
    end

    // Millisecond time base shared by all sequencers.
    st_d.msTick = 1'b0;
    if (st_q.msCnt >= 32'(MS_COUNT - 1))
    begin
      st_d.msCnt = 32'h0;
      st_d.msTick = 1'b1;
    end
    else
    begin
      st_d.msCnt = st_q.msCnt + 32'h1;
    end

    // Register writes.
    if (regWr)
    begin
      case (regAddr)
        OFS_CTRL: st_d.ctrl = regWdata[2:0];
        OFS_MULT: st_d.multCode = regWdata[POS_MULT+2:POS_MULT]; // RL5
        OFS_RAMP: st_d.rampMs = regWdata[7:0];
        default: ;
      endcase
    end

    // Register reads; data stand in the following cycle only.
    st_d.rdata = 32'h0;
    if (regRd)
    begin
      case (regAddr)
        OFS_CTRL: st_d.rdata = {29'h0, st_q.ctrl};
        OFS_MULT: st_d.rdata = {24'h0, st_q.multCode, 5'h0};
        OFS_RAMP: st_d.rdata = {24'h0, st_q.rampMs};
        OFS_STAT: st_d.rdata = {20'h0, biased, st_q.chOff, st_q.anaEn, 3'h0, st_q.seq};
        default:
        begin
          if (rdHit)
          begin
            st_d.rdata = {24'h0, st_q.fault[rdIdx[1:0]]};
          end
        end
      endcase
    end
    if (rdHit && rdIdx == 3'h3)
    begin
      st_d.fault = '0; // RL21
    end

    // Test current outputs per channel, chosen by the mode bits.
    for (int c = 0; c < 4; c++)
    begin
      // Thresholds follow the next mode bits so they change together with lineModeOut.
      st_d.shortThr[c] = lineModeOf(st_d.ctrl, c) ? SHORT_LINE_MA : SHORT_SPK_MA; // RL7
      st_d.openThr[c] = lineModeOf(st_d.ctrl, c) ? OPEN_LINE_MA : OPEN_SPK_MA; // RL8
    end

    // Turn-on pulse sequencer, started by enabling diagnostics while unbiased.
    st_d.diagPrev = diagEn;
    if (st_q.seq != SEQ_IDLE && st_q.msTick && st_q.seqCnt != 10'h0)
    begin
      st_d.seqCnt = st_q.seqCnt - 10'h1;
    end
    case (st_q.seq)
      SEQ_IDLE:
      begin
        st_d.anaEn = 1'b0;
        if (diagEn && !st_q.diagPrev && !biased)
        begin
          st_d.seq = SEQ_SS_UP;
          st_d.seqCnt = RISE_MS; // RL2
          st_d.seqRes = '0;
        end
      end
      SEQ_SS_UP:
      begin
        if (st_q.seqCnt == 10'h0)
        begin
          st_d.seq = SEQ_SS_PLAT;
          st_d.seqCnt = SHORT_PLAT_MS; // RL4
        end
      end
      SEQ_SS_PLAT:
      begin
        if (st_q.seqCnt == 10'h0)
        begin
          for (int c = 0; c < 4; c++)
          begin
            st_d.seqRes[c][POS_GND] = sGnd[c];
            st_d.seqRes[c][POS_VS] = sVs[c];
            st_d.seqRes[c][POS_VALID] = !(sGnd[c] || sVs[c]);
          end
          st_d.seq = SEQ_SS_DN;
          st_d.seqCnt = RISE_MS; // RL3
        end
      end
      SEQ_SS_DN:
      begin
        if (st_q.seqCnt == 10'h0)
        begin
          st_d.seq = SEQ_LD_UP;
          st_d.anaEn = 1'b1;
          st_d.seqCnt = upMs; // RL2
        end
      end
      SEQ_LD_UP:
      begin
        if (st_q.seqCnt == 10'h0)
        begin
          st_d.seq = SEQ_LD_PLAT;
          st_d.seqCnt = tpMs; // RL6
        end
      end
      SEQ_LD_PLAT:
      begin
        if (st_q.seqCnt == 10'h0)
        begin
          for (int c = 0; c < 4; c++)
          begin
            // Line mode thresholds sit near 20 ohm and 3 kohm.
            st_d.seqRes[c][POS_ACROSS] = hiCur[c]; // RL1
            st_d.seqRes[c][POS_OPEN] = !loCur[c]; // RL1
          end
          st_d.seq = SEQ_LD_DN;
          st_d.seqCnt = upMs; // RL3
        end
      end
      SEQ_LD_DN:
      begin
        if (st_q.seqCnt == 10'h0)
        begin
          st_d.seq = SEQ_IDLE;
          st_d.anaEn = 1'b0;
          st_d.fault = st_q.seqRes; // RL10
        end
      end
      default: st_d.seq = SEQ_IDLE;
    endcase

    // Permanent diagnostic, one sequencer per channel.
    for (int c = 0; c < 4; c++) // RL23
    begin
      if (st_q.msTick && st_q.chCnt[c] != 7'h0)
      begin
        st_d.chCnt[c] = st_q.chCnt[c] - 7'h1;
      end
      case (st_q.chSt[c])
        CH_PLAY:
        begin
          st_d.chOff[c] = 1'b0;
          if (biased && oc[c])
          begin
            st_d.chOff[c] = 1'b1; // RL14
            st_d.chSt[c] = CH_RESTART;
            st_d.chCnt[c] = RESTART_MS; // RL12
            st_d.first[c] = 1'b1; // RL16
          end
        end
        CH_RESTART:
        begin
          if (rdHit && oc[c] && diagEn)
          begin
            st_d.replot[c] = 1'b1; // RL20
          end
          if (st_q.chCnt[c] == 7'h0)
          begin
            if (!oc[c])
            begin
              st_d.chSt[c] = CH_PLAY; // RL16 RL14
              st_d.chOff[c] = 1'b0;
              st_d.replot[c] = 1'b0; // RL20
            end
            else if (biased && diagEn && (st_q.first[c] || st_q.replot[c]))
            begin
              st_d.chSt[c] = CH_PLATEAU; // RL17 RL9
              st_d.chCnt[c] = PLATEAU_MS; // RL13
              st_d.acc[c] = 3'h0;
              st_d.replot[c] = 1'b0;
            end
            else
            begin
              st_d.chCnt[c] = RESTART_MS; // RL18 RL14
            end
            st_d.first[c] = 1'b0;
          end
        end
        CH_PLATEAU:
        begin
          // Only hard shorts and short across are gathered here.
          st_d.acc[c] = st_q.acc[c] | {sAcross[c], sVs[c], sGnd[c]}; // RL11
          if (st_q.chCnt[c] == 7'h0)
          begin
            st_d.fault[c][POS_GND] = st_q.acc[c][0]; // RL13
            st_d.fault[c][POS_VS] = st_q.acc[c][1]; // RL13
            st_d.fault[c][POS_ACROSS] = st_q.acc[c][2]; // RL13
            st_d.fault[c][POS_PLAT_DONE] = 1'b1; // RL19
            st_d.chSt[c] = CH_RESTART; // RL18
            st_d.chCnt[c] = RESTART_MS;
          end
        end
        default: st_d.chSt[c] = CH_PLAY;
      endcase
      // Diagnostics off holds the permanent fault bits at zero, even at a plateau's end.
      if (!diagEn)
      begin
        st_d.fault[c][POS_GND] = 1'b0; // RL15
        st_d.fault[c][POS_VS] = 1'b0; // RL15
        st_d.fault[c][POS_ACROSS] = 1'b0; // RL15
        st_d.fault[c][POS_PLAT_DONE] = 1'b0; // RL15
        st_d.replot[c] = 1'b0;
      end
      st_d.platOut[c] = (st_d.chSt[c] == CH_PLATEAU);
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
      st_q.rampMs <= RAMP_RST;
      st_q.seq <= SEQ_IDLE;
      st_q.chSt <= '{default: CH_PLAY};
      st_q.shortThr <= {SHORT_SPK_MA, SHORT_SPK_MA, SHORT_SPK_MA, SHORT_SPK_MA};
      st_q.openThr <= {OPEN_SPK_MA, OPEN_SPK_MA, OPEN_SPK_MA, OPEN_SPK_MA};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign regRdata = st_q.rdata;
  assign chanShutdown = st_q.chOff;
  assign seqPhase = st_q.seq;
  assign analogSupplyEn = st_q.anaEn;
  assign shortTestCurrent = st_q.shortThr;
  assign openTestCurrent = st_q.openThr;
  assign lineModeOut = {st_q.ctrl[POS_MODE_24], st_q.ctrl[POS_MODE_13],
                        st_q.ctrl[POS_MODE_24], st_q.ctrl[POS_MODE_13]};
  assign chanPlateau = st_q.platOut;

endmodule : afds_top
`default_nettype wire

// File: afds_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module afds_checker
  import afds_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic ampBiasedPin,
  input wire logic [3:0] chanShutdown,
  input wire logic [3:0] chanPlateau,
  input wire logic [2:0] seqPhase,
  input wire logic analogSupplyEn,
  input wire logic [3:0] lineModeOut,
  input wire logic [31:0] shortTestCurrent,
  input wire logic [31:0] openTestCurrent
);
  logic [2:0] phPrev;
  int phCnt;
  int plCnt;
  // Cycles spent in the previous phase and in the channel two plateau.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phPrev <= 3'h0;
      phCnt <= 0;
      plCnt <= 0;
    end
    else
    begin
      phPrev <= seqPhase;
      phCnt <= (seqPhase != phPrev) ? 1 : phCnt + 1;
      plCnt <= chanPlateau[1] ? plCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_pair;
    lineModeOut[0] == lineModeOut[2] && lineModeOut[1] == lineModeOut[3];
  endproperty
  a_pair: assert property (p_pair) else $error("pair mode split");
  property p_ishort;
    shortTestCurrent[15:8] == (lineModeOut[1] ? SHORT_LINE_MA : SHORT_SPK_MA);
  endproperty
  a_ishort: assert property (p_ishort) else $error("short current wrong");
  property p_iopen;
    openTestCurrent[7:0] == (lineModeOut[0] ? OPEN_LINE_MA : OPEN_SPK_MA);
  endproperty
  a_iopen: assert property (p_iopen) else $error("open current wrong");
  property p_supply;
    analogSupplyEn == (seqPhase inside {3'h4, 3'h5, 3'h6});
  endproperty
  a_supply: assert property (p_supply) else $error("supply out of phase");
  property p_order;
    $changed(seqPhase) |-> seqPhase == $past(seqPhase) + 3'h1 || seqPhase == 3'h0;
  endproperty
  a_order: assert property (p_order) else $error("phase order broken");
  property p_rise;
    seqPhase == 3'h2 && phPrev == 3'h1 |-> phCnt inside {[9 * MS_COUNT:10 * MS_COUNT + 1]};
  endproperty
  a_rise: assert property (p_rise) else $error("ramp up length");
  property p_splat;
    seqPhase == 3'h3 && phPrev == 3'h2 |-> phCnt inside {[79 * MS_COUNT:80 * MS_COUNT + 1]};
  endproperty
  a_splat: assert property (p_splat) else $error("short plateau length");
  property p_fall;
    seqPhase == 3'h4 && phPrev == 3'h3 |-> phCnt inside {[9 * MS_COUNT:10 * MS_COUNT + 1]};
  endproperty
  a_fall: assert property (p_fall) else $error("ramp down length");
  property p_rise2;
    seqPhase == 3'h5 && phPrev == 3'h4 |-> phCnt inside {[19 * MS_COUNT:20 * MS_COUNT + 1]};
  endproperty
  a_rise2: assert property (p_rise2) else $error("supply ramp length");
  property p_plat;
    $fell(chanPlateau[1]) |-> plCnt inside {[79 * MS_COUNT:80 * MS_COUNT + 1]};
  endproperty
  a_plat: assert property (p_plat) else $error("plateau cycle length");
  property p_bias;
    $rose(chanShutdown[1]) |-> $past(ampBiasedPin, 4);
  endproperty
  a_bias: assert property (p_bias) else $error("shutdown while unbiased");
  c_plat: cover property (chanPlateau[1]);
  c_load: cover property (seqPhase == 3'h5);
  c_restart: cover property (chanShutdown[0] && !chanPlateau[0]);
endmodule : afds_checker
bind afds_top afds_checker #(.MS_COUNT(MS_COUNT)) u_chk (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .ampBiasedPin(ampBiasedPin),
  .chanShutdown(chanShutdown),
  .chanPlateau(chanPlateau),
  .seqPhase(seqPhase),
  .analogSupplyEn(analogSupplyEn),
  .lineModeOut(lineModeOut),
  .shortTestCurrent(shortTestCurrent),
  .openTestCurrent(openTestCurrent)
);
`default_nettype wire

// File: afds_load_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Loads and power stage sense
// ----------------------------------------
module afds_load_model
(
  // Injected faults
  input wire logic [3:0] gnd,
  input wire logic [3:0] vs,
  input wire logic [3:0] acr,
  input wire logic [3:0] opn,
  input wire logic biased,
  // Sense pins
  output logic [3:0] oc,
  output logic [3:0] sGnd,
  output logic [3:0] sVs,
  output logic [3:0] sAcr,
  output logic [3:0] rShort,
  output logic [3:0] rOpen,
  output logic bPin
);
  // A hard short draws over-current only while the stage is biased.
  assign oc = (gnd | vs | acr) & {4{biased}};
  assign sGnd = gnd;
  assign sVs = vs;
  assign sAcr = acr;
  assign rShort = acr;
  assign rOpen = ~opn;
  assign bPin = biased;
endmodule : afds_load_model
`default_nettype wire

// File: afds_tb.sv
`timescale 1ns/100ps
`default_nettype none
module afds_tb
  import afds_pkg::*;
;
  localparam int MS = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] gnd = 4'h0;
  logic [3:0] opn = 4'h0;
  logic [3:0] vs = 4'h0;
  logic [3:0] acr = 4'h0;
  logic biased = 1'b0;
  wire logic [3:0] oc, sGnd, sVs, sAcr, rShort, rOpen;
  wire logic bPin;
  logic [3:0] shut, plat, lineMode;
  logic [2:0] phase;
  logic supEn;
  logic [31:0] iShort, iOpen, rd, regRdata;
  int fail_count = 0;
  int total_checks = 0;
  always #2.5 mclk = ~mclk;
  afds_load_model load (.gnd(gnd), .vs(vs), .acr(acr), .opn(opn), .biased(biased),
    .oc(oc), .sGnd(sGnd), .sVs(sVs), .sAcr(sAcr), .rShort(rShort), .rOpen(rOpen), .bPin(bPin));
  afds_top #(.MS_COUNT(MS)) dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .overCurrentPin(oc), .shortGndPin(sGnd), .shortVsPin(sVs), .shortAcrossPin(sAcr),
    .reachShortCurPin(rShort), .reachOpenCurPin(rOpen), .ampBiasedPin(bPin),
    .chanShutdown(shut), .chanPlateau(plat), .seqPhase(phase), .analogSupplyEn(supEn),
    .lineModeOut(lineMode), .shortTestCurrent(iShort), .openTestCurrent(iOpen));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rdReg
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic waitCh(input bit sel, input int ch, input logic lvl, input int lim,
      output int n);
    for (n = 0; n < lim && (sel ? plat[ch] : shut[ch]) !== lvl; n++)
      tick(1);
  endtask : waitCh
  task automatic quietPlat(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      tick(1);
      seen = seen | (|plat);
    end
    check(32'(seen), 32'h0);
  endtask : quietPlat
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial
  begin
    #300000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    int n;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(2);
    check(iShort, {4{SHORT_SPK_MA}});
    check(iOpen, {4{OPEN_SPK_MA}});
    rdReg(OFS_RAMP, rd);
    check(rd, {24'h0, RAMP_RST});
    rdReg(8'hF0, rd);
    check(rd, 32'h0);
    wr(OFS_CTRL, 32'h4);
    tick(2);
    check({28'h0, lineMode}, 32'h5);
    check(iOpen, {OPEN_SPK_MA, OPEN_LINE_MA, OPEN_SPK_MA, OPEN_LINE_MA});
    wr(OFS_CTRL, 32'h2);
    tick(2);
    check(iShort, {SHORT_LINE_MA, SHORT_SPK_MA, SHORT_LINE_MA, SHORT_SPK_MA});
    @(posedge mclk);
    opn <= 4'h8;
    wr(OFS_MULT, 32'h20);
    wr(OFS_CTRL, 32'h1);
    for (n = 0; n < 8000 && phase !== 3'h5; n++)
      tick(1);
    for (n = 0; n < 5000 && phase === 3'h5; n++)
      tick(1);
    check(32'(n >= 171 * MS && n <= 172 * MS + 1), 32'h1);
    for (n = 0; n < 1000 && phase !== 3'h0; n++)
      tick(1);
    tick(2);
    for (int c = 0; c < 4; c++)
    begin
      rdReg(OFS_FAULT0 + 8'(4 * c), rd);
      check(rd, c == 3 ? 32'h44 : 32'h40);
    end
    rdReg(OFS_FAULT0, rd);
    check(rd, 32'h0);
    wr(OFS_CTRL, 32'h0);
    biased <= 1'b1;
    tick(10);
    @(posedge mclk);
    gnd <= 4'h1;
    waitCh(1'b0, 0, 1'b1, 10, n);
    check({28'h0, shut}, 32'h1);
    rdReg(OFS_STAT, rd);
    check(rd, 32'h880);
    quietPlat(6 * MS);
    rdReg(OFS_FAULT0, rd);
    check(rd, 32'h0);
    @(posedge mclk);
    gnd <= 4'h0;
    waitCh(1'b0, 0, 1'b0, 2 * MS + 8, n);
    check(32'(shut[0]), 32'h0);
    wr(OFS_CTRL, 32'h1);
    @(posedge mclk);
    gnd <= 4'h4;
    repeat (8) @(posedge mclk);
    gnd <= 4'h2;
    waitCh(1'b1, 1, 1'b1, 3 * MS, n);
    check(32'(n <= 2 * MS + 8), 32'h1);
    check({28'h0, plat}, 32'h2);
    waitCh(1'b1, 1, 1'b0, 81 * MS, n);
    check({28'h0, shut}, 32'h2);
    rdReg(OFS_FAULT0 + 8'h4, rd);
    check(rd, 32'h21);
    waitCh(1'b1, 1, 1'b1, 3 * MS, n);
    check(32'(n <= 2 * MS + 8), 32'h1);
    waitCh(1'b1, 1, 1'b0, 81 * MS, n);
    quietPlat(5 * MS);
    @(posedge mclk);
    gnd <= 4'h0;
    waitCh(1'b0, 1, 1'b0, 2 * MS + 8, n);
    check(32'(shut[1]), 32'h0);
    // Channel four: short to supply and across load beside an open load.
    @(posedge mclk);
    vs <= 4'h8;
    acr <= 4'h8;
    waitCh(1'b1, 3, 1'b1, 3 * MS, n);
    waitCh(1'b1, 3, 1'b0, 81 * MS, n);
    rdReg(OFS_FAULT0 + 8'hC, rd);
    check(rd, 32'h2A);
    rdReg(OFS_FAULT0 + 8'h4, rd);
    check(rd, 32'h0);
    waitCh(1'b1, 3, 1'b1, 3 * MS, n);
    check(32'(n <= 2 * MS + 8), 32'h1);
    waitCh(1'b1, 3, 1'b0, 81 * MS, n);
    wr(OFS_CTRL, 32'h0);
    rdReg(OFS_FAULT0 + 8'hC, rd);
    check(rd, 32'h0);
    @(posedge mclk);
    vs <= 4'h0;
    acr <= 4'h0;
    waitCh(1'b0, 3, 1'b0, 2 * MS + 8, n);
    check(32'(shut[3]), 32'h0);
    end_of_test();
  end
endmodule : afds_tb
`default_nettype wire
